// ### hw/bgp_pkg.sv
// Shared constants for the buck gate protection control block.
// Assumes a 200 MHz logic clock and a switching-cycle tick from the ramp oscillator.
package bgp_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int DEAD_TIME_NSEC = 20;
  localparam int DEAD_CYC = (DEAD_TIME_NSEC * CLK_MHZ + 999) / 1000;
  localparam int BLANK_TIME_NSEC = 300;
  localparam int BLANK_CYC = (BLANK_TIME_NSEC * CLK_MHZ + 999) / 1000;
  localparam int SOFT_START_CYCLES = 2048;

  // ****************************************************************
  // Widths and counter limits
  // ****************************************************************
  localparam int LEVEL_W = 12;
  localparam int PROD_W = 20;
  localparam int SELECT_W = 5;
  localparam int DROP_W = 10;
  localparam int SS_W = 12;
  localparam int DT_W = 4;
  localparam int BLK_W = 7;
  localparam logic [SS_W-1:0] SS_LAST = SS_W'(SOFT_START_CYCLES - 1);
  localparam logic [DT_W-1:0] DT_LAST = DT_W'(DEAD_CYC - 1);
  localparam logic [BLK_W-1:0] BLK_LAST = BLK_W'(BLANK_CYC - 1);

  // ****************************************************************
  // Window limits in percent
  // ****************************************************************
  localparam int PCT_FULL = 100;
  localparam int PCT_FAST = 5;
  localparam int PCT_GOOD = 10;
  localparam int PCT_OVER = 15;

  // ****************************************************************
  // Converter states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SOFT,
    ST_RUN,
    ST_OVLATCH
  } bgp_state_t;

endpackage

// ### hw/bgp_window_cmp.sv
// Window comparator of a sampled output level against a target level.
// Assumes both levels are sampled on clk and are in the same units.
`timescale 1ns/1ps
module bgp_window_cmp
  import bgp_pkg::*;
#(
  parameter int PCT = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Levels
  input wire logic [LEVEL_W-1:0] sampleLevel,
  input wire logic [LEVEL_W-1:0] targetLevel,
  // Results
  output logic aboveWindow_ff,
  output logic belowWindow_ff
);

  localparam logic [7:0] HI_MUL = 8'(PCT_FULL + PCT);
  localparam logic [7:0] LO_MUL = 8'(PCT_FULL - PCT);
  localparam logic [7:0] ONE_MUL = 8'(PCT_FULL);

  // Scaling both sides by percent keeps the thresholds exact.
  wire logic [PROD_W-1:0] scaledSample;
  wire logic [PROD_W-1:0] hiLimit;
  wire logic [PROD_W-1:0] loLimit;
  assign scaledSample = PROD_W'(sampleLevel) * PROD_W'(ONE_MUL);
  assign hiLimit = PROD_W'(targetLevel) * PROD_W'(HI_MUL);
  assign loLimit = PROD_W'(targetLevel) * PROD_W'(LO_MUL);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aboveWindow_ff <= 1'b0;
      belowWindow_ff <= 1'b0;
    end else begin
      aboveWindow_ff <= scaledSample > hiLimit;
      belowWindow_ff <= scaledSample < loLimit;
    end
  end

endmodule

// ### hw/bgp_dead_time.sv
// Non-overlap interlock for the upper and lower switch drives.
// Assumes off-confirm inputs are high once the external gate is fully discharged.
`timescale 1ns/1ps
module bgp_dead_time
  import bgp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Requested drive state
  input wire logic upperReq,
  input wire logic lowerReq,
  // Gate off confirmation from the power stage
  input wire logic upperOffConfirm,
  input wire logic lowerOffConfirm,
  // Gate drives
  output logic upperSwitchDrive_ff,
  output logic lowerSwitchDrive_ff
);

  logic [DT_W-1:0] deadCnt_ff;
  logic [DT_W-1:0] nxt_deadCnt;

  // Dead time runs only while both drives are low and both gates read off.
  wire logic bothOff;
  wire logic deadDone;
  wire logic upperGo;
  wire logic lowerGo;
  assign bothOff = !upperSwitchDrive_ff && !lowerSwitchDrive_ff
                   && upperOffConfirm && lowerOffConfirm;
  assign deadDone = bothOff && (deadCnt_ff == DT_LAST);
  assign upperGo = upperReq && !lowerReq && deadDone;
  assign lowerGo = lowerReq && !upperReq && deadDone;
  assign nxt_deadCnt = !bothOff ? '0 : (deadDone ? deadCnt_ff : deadCnt_ff + 1'b1);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      deadCnt_ff <= '0;
    end else begin
      deadCnt_ff <= nxt_deadCnt;
    end
  end

  // Turn-off is immediate; turn-on waits for the other side and the dead time.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upperSwitchDrive_ff <= 1'b0;
      lowerSwitchDrive_ff <= 1'b0;
    end else begin
      upperSwitchDrive_ff <= upperReq && (upperSwitchDrive_ff || upperGo);
      lowerSwitchDrive_ff <= lowerReq && (lowerSwitchDrive_ff || lowerGo);
    end
  end

endmodule

// ### hw/bgp_gate_protect.sv
// Gate sequencing and protection top for a synchronous buck controller.
// Assumes the ramp oscillator gives a one-cycle tick per switching cycle,
// the PWM comparator result and all sampled levels are synchronous to clk,
// and rst_b is the supply power-on reset.
//
// Function
// - Never turn a drive on before the other is off; insert about 20 nanoseconds dead time.
// - In regulation, gate on-times follow the error-amplifier versus ramp pulse train.
// - After soft start, flag fast under and over events outside plus or minus 5 percent of target.
// - During fast events bypass the loop: full duty on under, zero on over.
// - Output counts as good only within plus or minus 10 percent of target.
// - Hold the power-good flag low throughout soft start.
// - At soft start end assert power good if in range, then follow the monitor.
// - After soft start, latch over-voltage shutdown when output exceeds 115 percent.
// - In shutdown hold upper drive low, lower drive high, power good low.
// - Enable toggle or power-on reset clears the shutdown latch.
// - Releasing all selection inputs then reapplying a valid code clears the latch.
// - While upper switch is on, flag over-current when switch drop exceeds limit drop.
// - Ignore the over-current comparison for about 300 nanoseconds after each upper turn-on.
// - Over-current ends the upper pulse, turns lower on, until next cycle starts.
// - Soft start lasts 2,048 switching cycles before releasing the error amplifier.
// - Clearing the shutdown latch restarts with a fresh soft start.
// - During power-on reset hold all logic reset and both drives off.
// - Start soft start only when out of reset, enabled and code valid.
`timescale 1ns/1ps
module bgp_gate_protect
  import bgp_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst_b,
  // Converter control
  input wire logic converterEnableInput,
  input wire logic [SELECT_W-1:0] voltageSelectCode,
  input wire logic selectReleased,
  // Loop and timing
  input wire logic pwmCompare,
  input wire logic cycleStart,
  // Sampled levels
  input wire logic [LEVEL_W-1:0] outputLevel,
  input wire logic [LEVEL_W-1:0] targetLevel,
  input wire logic [DROP_W-1:0] switchDrop,
  input wire logic [DROP_W-1:0] limitDrop,
  // Power stage feedback
  input wire logic upperOffConfirm,
  input wire logic lowerOffConfirm,
  // Gate drives
  output logic upperSwitchDrive,
  output logic lowerSwitchDrive,
  // Status
  output logic outputInRangeFlag,
  output logic overvoltageShutdownLatch,
  output logic fastUnderFlag,
  output logic fastOverFlag,
  output logic overCurrentFlag,
  output logic softStartActive,
  output logic errorAmpRelease,
  output logic [SELECT_W-1:0] activeSelectCode
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  bgp_state_t state_ff;
  bgp_state_t nxt_state;
  logic [SS_W-1:0] ssCnt_ff;
  logic [SS_W-1:0] nxt_ssCnt;
  logic [BLK_W-1:0] blankCnt_ff;
  logic [BLK_W-1:0] nxt_blankCnt;
  logic blankDone_ff;
  logic nxt_blankDone;
  logic ocCut_ff;
  logic nxt_ocCut;
  logic enablePrev_ff;
  logic releasedSeen_ff;
  logic nxt_releasedSeen;
  logic upperPrev_ff;
  logic inRange_ff;
  logic ovLatch_ff;
  logic fastUnder_ff;
  logic fastOver_ff;
  logic ocFlag_ff;
  logic ssActive_ff;
  logic eaRelease_ff;
  logic [SELECT_W-1:0] selCode_ff;
  logic fastAbove;
  logic fastBelow;
  logic goodAbove;
  logic goodBelow;
  logic ovAbove;
  logic upperReq;
  logic lowerReq;
  logic upperDriveQ;
  logic lowerDriveQ;

  // ****************************************************************
  // Window monitors
  // ****************************************************************
  bgp_window_cmp #(.PCT(PCT_FAST)) uFastWin (
    .clk(clk),
    .rst_b(rst_b),
    .sampleLevel(outputLevel),
    .targetLevel(targetLevel),
    .aboveWindow_ff(fastAbove),
    .belowWindow_ff(fastBelow)
  );

  bgp_window_cmp #(.PCT(PCT_GOOD)) uGoodWin (
    .clk(clk),
    .rst_b(rst_b),
    .sampleLevel(outputLevel),
    .targetLevel(targetLevel),
    .aboveWindow_ff(goodAbove),
    .belowWindow_ff(goodBelow)
  );

  bgp_window_cmp #(.PCT(PCT_OVER)) uOverWin (
    .clk(clk),
    .rst_b(rst_b),
    .sampleLevel(outputLevel),
    .targetLevel(targetLevel),
    .aboveWindow_ff(ovAbove),
    .belowWindow_ff()
  );

  // ****************************************************************
  // Start conditions and latch release
  // ****************************************************************
  wire logic codeValid;
  wire logic startOk;
  wire logic enableToggle;
  wire logic reapplied;
  wire logic latchClear;
  wire logic running;
  wire logic ssDone;
  assign codeValid = !selectReleased;
  assign startOk = converterEnableInput && codeValid;
  assign enableToggle = converterEnableInput != enablePrev_ff;
  assign reapplied = releasedSeen_ff && codeValid;
  assign latchClear = enableToggle || reapplied;
  assign running = state_ff == ST_RUN;
  assign ssDone = cycleStart && (ssCnt_ff == SS_LAST);

  // Release of the selection inputs is remembered only while latched.
  assign nxt_releasedSeen = (state_ff == ST_OVLATCH) && !reapplied
                            && (releasedSeen_ff || selectReleased);

  // ****************************************************************
  // State sequencing
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (startOk) begin
          nxt_state = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (!startOk) begin
          nxt_state = ST_IDLE;
        end else if (ssDone) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!startOk) begin
          nxt_state = ST_IDLE;
        end else if (ovAbove) begin
          nxt_state = ST_OVLATCH;
        end
      end
      ST_OVLATCH: begin
        if (latchClear) begin
          nxt_state = startOk ? ST_SOFT : ST_IDLE;
        end
      end
    endcase
  end

  // The soft-start counter is cleared on every entry to soft start.
  assign nxt_ssCnt = (state_ff != ST_SOFT) ? '0 : (cycleStart ? ssCnt_ff + 1'b1 : ssCnt_ff);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_IDLE;
      ssCnt_ff <= '0;
      enablePrev_ff <= 1'b0;
      releasedSeen_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ssCnt_ff <= nxt_ssCnt;
      enablePrev_ff <= converterEnableInput;
      releasedSeen_ff <= nxt_releasedSeen;
    end
  end

  // ****************************************************************
  // Over-current blanking and cutoff
  // ****************************************************************
  wire logic upperRise;
  wire logic ocCompare;
  wire logic ocTrip;
  assign upperRise = upperDriveQ && !upperPrev_ff;
  assign ocCompare = switchDrop > limitDrop;
  assign ocTrip = upperDriveQ && blankDone_ff && ocCompare;

  // Blanking restarts on each upper turn-on and is void while the switch is off.
  assign nxt_blankCnt = upperRise ? '0 : (blankDone_ff ? blankCnt_ff : blankCnt_ff + 1'b1);
  assign nxt_blankDone = upperDriveQ && !upperRise
                         && (blankDone_ff || blankCnt_ff == BLK_LAST);

  // A trip in the same cycle as a new cycle start still wins.
  assign nxt_ocCut = ocTrip || (ocCut_ff && !cycleStart);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blankCnt_ff <= '0;
      blankDone_ff <= 1'b0;
      ocCut_ff <= 1'b0;
      upperPrev_ff <= 1'b0;
    end else begin
      blankCnt_ff <= nxt_blankCnt;
      blankDone_ff <= nxt_blankDone;
      ocCut_ff <= nxt_ocCut;
      upperPrev_ff <= upperDriveQ;
    end
  end

  // ****************************************************************
  // Drive demand in priority order
  // ****************************************************************
  wire logic regulating;
  wire logic fastUnderEvt;
  wire logic fastOverEvt;
  assign regulating = (state_ff == ST_SOFT) || running;
  assign fastUnderEvt = running && fastBelow;
  assign fastOverEvt = running && fastAbove;

  always_comb begin
    upperReq = 1'b0;
    lowerReq = 1'b0;
    if (state_ff == ST_OVLATCH) begin
      lowerReq = 1'b1;
    end else if (!regulating) begin
      lowerReq = 1'b0;
    end else if (ocTrip || ocCut_ff) begin
      lowerReq = 1'b1;
    end else if (fastUnderEvt) begin
      upperReq = 1'b1;
    end else if (fastOverEvt) begin
      lowerReq = 1'b1;
    end else begin
      upperReq = pwmCompare;
      lowerReq = !pwmCompare;
    end
  end

  bgp_dead_time uDeadTime (
    .clk(clk),
    .rst_b(rst_b),
    .upperReq(upperReq),
    .lowerReq(lowerReq),
    .upperOffConfirm(upperOffConfirm),
    .lowerOffConfirm(lowerOffConfirm),
    .upperSwitchDrive_ff(upperDriveQ),
    .lowerSwitchDrive_ff(lowerDriveQ)
  );

  assign upperSwitchDrive = upperDriveQ;
  assign lowerSwitchDrive = lowerDriveQ;

  // ****************************************************************
  // Status flags
  // ****************************************************************
  wire logic goodWindow;
  assign goodWindow = !goodAbove && !goodBelow;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inRange_ff <= 1'b0;
      ovLatch_ff <= 1'b0;
      fastUnder_ff <= 1'b0;
      fastOver_ff <= 1'b0;
      ocFlag_ff <= 1'b0;
      ssActive_ff <= 1'b0;
      eaRelease_ff <= 1'b0;
      selCode_ff <= '0;
    end else begin
      inRange_ff <= (nxt_state == ST_RUN) && goodWindow;
      ovLatch_ff <= nxt_state == ST_OVLATCH;
      fastUnder_ff <= fastUnderEvt;
      fastOver_ff <= fastOverEvt;
      ocFlag_ff <= ocTrip;
      ssActive_ff <= nxt_state == ST_SOFT;
      eaRelease_ff <= nxt_state == ST_RUN;
      selCode_ff <= codeValid ? voltageSelectCode : selCode_ff;
    end
  end

  assign outputInRangeFlag = inRange_ff;
  assign overvoltageShutdownLatch = ovLatch_ff;
  assign fastUnderFlag = fastUnder_ff;
  assign fastOverFlag = fastOver_ff;
  assign overCurrentFlag = ocFlag_ff;
  assign softStartActive = ssActive_ff;
  assign errorAmpRelease = eaRelease_ff;
  assign activeSelectCode = selCode_ff;

endmodule

// ### testbench/bgp_gate_monitor.sv
// Checker of the gate protection top, watching its ports only.
// Assumes one clock domain with rst_b as async active-low reset.
`timescale 1ns/1ps
module bgp_gate_monitor
  import bgp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Levels
  input wire logic [LEVEL_W-1:0] outputLevel,
  input wire logic [LEVEL_W-1:0] targetLevel,
  // Drives and status
  input wire logic upperSwitchDrive,
  input wire logic lowerSwitchDrive,
  input wire logic outputInRangeFlag,
  input wire logic overvoltageShutdownLatch,
  input wire logic fastUnderFlag,
  input wire logic fastOverFlag,
  input wire logic overCurrentFlag,
  input wire logic softStartActive,
  input wire logic errorAmpRelease
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [7:0] upOnCnt_ff;
  logic [3:0] loOffCnt_ff;
  logic [3:0] upOffCnt_ff;
  wire [PROD_W-1:0] outScaled = PROD_W'(outputLevel) * PROD_W'(PCT_FULL);
  wire [PROD_W-1:0] tgt = PROD_W'(targetLevel);
  wire ovHigh = outScaled > tgt * PROD_W'(PCT_FULL + PCT_OVER);
  wire goodWin = (outScaled >= tgt * PROD_W'(PCT_FULL - PCT_GOOD)) &&
                 (outScaled <= tgt * PROD_W'(PCT_FULL + PCT_GOOD));
  // Counters of how long each drive has been on or off.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upOnCnt_ff <= 8'h00;
      loOffCnt_ff <= 4'hf;
      upOffCnt_ff <= 4'hf;
    end else begin
      upOnCnt_ff <= !upperSwitchDrive ? 8'h00 : (&upOnCnt_ff ? upOnCnt_ff : upOnCnt_ff + 8'h01);
      loOffCnt_ff <= lowerSwitchDrive ? 4'h0 : (&loOffCnt_ff ? loOffCnt_ff : loOffCnt_ff + 4'h1);
      upOffCnt_ff <= upperSwitchDrive ? 4'h0 : (&upOffCnt_ff ? upOffCnt_ff : upOffCnt_ff + 4'h1);
    end
  end
  no_overlap_a: assert property (!(upperSwitchDrive && lowerSwitchDrive))
    else $error("both drives on");
  upper_gap_a: assert property ($rose(upperSwitchDrive) |-> $past(loOffCnt_ff) >= 4'(DEAD_CYC))
    else $error("upper on without dead time");
  lower_gap_a: assert property ($rose(lowerSwitchDrive) |-> $past(upOffCnt_ff) >= 4'(DEAD_CYC))
    else $error("lower on without dead time");
  shut_hold_a: assert property (overvoltageShutdownLatch && $past(overvoltageShutdownLatch)
    |-> !upperSwitchDrive && !outputInRangeFlag) else $error("shutdown drive wrong");
  shut_lower_a: assert property ($rose(overvoltageShutdownLatch) |-> ##[1:30] lowerSwitchDrive)
    else $error("lower not on in shutdown");
  ov_entry_a: assert property (errorAmpRelease && ovHigh |-> ##[1:4] overvoltageShutdownLatch)
    else $error("over-voltage not latched");
  soft_pg_a: assert property (softStartActive |-> !outputInRangeFlag)
    else $error("power good during soft start");
  soft_fast_a: assert property (!errorAmpRelease && !$past(errorAmpRelease)
    |-> !fastUnderFlag && !fastOverFlag) else $error("fast flag outside run");
  pg_follow_a: assert property (errorAmpRelease && $past(errorAmpRelease, 4) &&
    $past(goodWin, 2) == $past(goodWin, 3) && $past(goodWin, 3) == $past(goodWin, 4)
    |-> outputInRangeFlag == $past(goodWin, 3)) else $error("power good wrong");
  oc_blank_a: assert property ($rose(overCurrentFlag)
    |-> upOnCnt_ff >= 8'(BLANK_CYC)) else $error("trip in blanking");
  oc_cut_a: assert property ($rose(overCurrentFlag) |-> ##[0:3] !upperSwitchDrive)
    else $error("upper not cut on trip");
  ov_seen_c: cover property ($rose(overvoltageShutdownLatch));
  oc_seen_c: cover property ($rose(overCurrentFlag));
  under_seen_c: cover property ($rose(fastUnderFlag));
endmodule
bind bgp_gate_protect bgp_gate_monitor bgp_gate_monitor_i (
  .clk(clk), .rst_b(rst_b), .outputLevel(outputLevel), .targetLevel(targetLevel),
  .upperSwitchDrive(upperSwitchDrive), .lowerSwitchDrive(lowerSwitchDrive),
  .outputInRangeFlag(outputInRangeFlag), .overvoltageShutdownLatch(overvoltageShutdownLatch),
  .fastUnderFlag(fastUnderFlag), .fastOverFlag(fastOverFlag),
  .overCurrentFlag(overCurrentFlag), .softStartActive(softStartActive),
  .errorAmpRelease(errorAmpRelease)
);

// ### testbench/bgp_stage_model.sv
// Power stage model: reports each gate as off some cycles after its drive drops.
// Assumes drives are active high; slowOff lengthens the gate discharge.
`timescale 1ns/1ps
module bgp_stage_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Gate drives
  input wire logic upperDrive,
  input wire logic lowerDrive,
  input wire logic slowOff,
  // Off confirmation
  output logic upperOffConfirm,
  output logic lowerOffConfirm
);
  logic [3:0] upLow_ff;
  logic [3:0] loLow_ff;
  wire [3:0] offNeed = slowOff ? 4'h6 : 4'h2;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      upLow_ff <= 4'hf;
      loLow_ff <= 4'hf;
    end else begin
      upLow_ff <= upperDrive ? 4'h0 : (&upLow_ff ? upLow_ff : upLow_ff + 4'h1);
      loLow_ff <= lowerDrive ? 4'h0 : (&loLow_ff ? loLow_ff : loLow_ff + 4'h1);
    end
  end
  assign upperOffConfirm = !upperDrive && (upLow_ff >= offNeed);
  assign lowerOffConfirm = !lowerDrive && (loLow_ff >= offNeed);
endmodule

// ### testbench/test_bgp_gate_protect.sv
// Self-checking bench for the gate protection top.
// Assumes the stage model answers the drives; clk runs at 200 MHz.
`timescale 1ns/1ps
module test_bgp_gate_protect
  import bgp_pkg::*;
;
  logic clk, rst_b, en, rel, pwm, cs, slow, upC, loC;
  logic up, lo, pg, ovl, fu, fo, oc, ss, ear;
  logic [SELECT_W-1:0] sel, act;
  logic [LEVEL_W-1:0] lvl, tgt;
  logic [DROP_W-1:0] sw, lim;
  int badCount, compares;
  bgp_gate_protect bgp_gate_protect_i (
    .clk(clk), .rst_b(rst_b), .converterEnableInput(en), .voltageSelectCode(sel),
    .selectReleased(rel), .pwmCompare(pwm), .cycleStart(cs), .outputLevel(lvl),
    .targetLevel(tgt), .switchDrop(sw), .limitDrop(lim), .upperOffConfirm(upC),
    .lowerOffConfirm(loC), .upperSwitchDrive(up), .lowerSwitchDrive(lo),
    .outputInRangeFlag(pg), .overvoltageShutdownLatch(ovl), .fastUnderFlag(fu),
    .fastOverFlag(fo), .overCurrentFlag(oc), .softStartActive(ss),
    .errorAmpRelease(ear), .activeSelectCode(act));
  bgp_stage_model bgp_stage_model_i (
    .clk(clk), .rst_b(rst_b), .upperDrive(up), .lowerDrive(lo), .slowOff(slow),
    .upperOffConfirm(upC), .lowerOffConfirm(loC));
  // ********
  // Helpers
  // ********
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task chk(input string nm, input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      badCount++;
      $display("[ERR] %s exp %b got %b", nm, exp, got);
    end
  endtask
  task pulse();
    @(negedge clk) cs = 1'b1;
    @(negedge clk) cs = 1'b0;
  endtask
  task waitDrv(input logic low, input logic want, input string nm);
    int i;
    i = 0;
    while ((low ? lo : up) !== want && i < 60) begin
      tick(1);
      i++;
    end
    chk(nm, low ? lo : up, want);
  endtask
  task softRun();
    for (int i = 0; i < SOFT_START_CYCLES - 1; i++) begin
      pulse();
      tick(2);
    end
    chk("ss on", ss, 1'b1);
    chk("pg soft", pg, 1'b0);
    chk("ear soft", ear, 1'b0);
    pulse();
    tick(2);
    chk("ear run", ear, 1'b1);
    chk("ss off", ss, 1'b0);
    tick(4);
    chk("pg run", pg, 1'b1);
  endtask
  task conclude();
    $display("compares %0d badCount %0d", compares, badCount);
    if (badCount == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ********
  // Scenarios
  // ********
  task idleCheck();
    tick(5);
    chk("idle en", ss, 1'b0);
    en = 1'b1;
    rel = 1'b1;
    tick(5);
    chk("idle rel", ss, 1'b0);
    rel = 1'b0;
    tick(3);
    chk("start", ss, 1'b1);
    chk("code", act === 5'h0a, 1'b1);
  endtask
  task startCheck();
    lvl = 12'h4b0;
    tick(10);
    chk("ov soft", ovl, 1'b0);
    chk("fo soft", fo, 1'b0);
    lvl = 12'h3e8;
    softRun();
  endtask
  task pwmCheck();
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      pwm = 1'b1;
      waitDrv(1'b0, 1'b1, "pwm up");
      chk("pwm lo off", lo, 1'b0);
      pwm = 1'b0;
      waitDrv(1'b1, 1'b1, "pwm lo");
      chk("pwm up off", up, 1'b0);
    end
    slow = 1'b0;
  endtask
  task fastCheck();
    lvl = 12'h370;
    waitDrv(1'b0, 1'b1, "under up");
    chk("under flag", fu, 1'b1);
    lvl = 12'h3e8;
    waitDrv(1'b1, 1'b1, "under end");
    pwm = 1'b1;
    waitDrv(1'b0, 1'b1, "over pre");
    lvl = 12'h424;
    waitDrv(1'b1, 1'b1, "over lo");
    chk("over flag", fo, 1'b1);
    chk("pg 6pct", pg, 1'b1);
    lvl = 12'h460;
    tick(4);
    chk("pg 12pct", pg, 1'b0);
    lvl = 12'h3e8;
    tick(4);
    chk("pg back", pg, 1'b1);
    pwm = 1'b0;
  endtask
  task ocCheck();
    int n;
    logic seen;
    n = 0;
    seen = 1'b0;
    sw = 10'h12c;
    tick(10);
    chk("oc off", oc, 1'b0);
    pwm = 1'b1;
    pulse();
    waitDrv(1'b0, 1'b1, "oc up");
    while (up === 1'b1 && n < 100) begin
      seen = seen | (oc === 1'b1);
      tick(1);
      n++;
    end
    seen = seen | (oc === 1'b1);
    chk("oc flag", seen, 1'b1);
    chk("blank", n >= BLANK_CYC - 2 && n <= BLANK_CYC + 8, 1'b1);
    waitDrv(1'b1, 1'b1, "oc lo");
    tick(20);
    chk("oc hold", up, 1'b0);
    sw = 10'h000;
    pulse();
    waitDrv(1'b0, 1'b1, "oc resume");
  endtask
  task ovCheck();
    slow = 1'b1;
    lvl = 12'h4b0;
    tick(4);
    chk("ov latch", ovl, 1'b1);
    chk("ov pg", pg, 1'b0);
    waitDrv(1'b1, 1'b1, "ov lo");
    chk("ov up", up, 1'b0);
    lvl = 12'h3e8;
    tick(10);
    chk("ov stays", ovl, 1'b1);
    en = 1'b0;
    tick(3);
    chk("ov clear", ovl, 1'b0);
    en = 1'b1;
    tick(3);
    chk("ov restart", ss, 1'b1);
    pwm = 1'b0;
    slow = 1'b0;
    softRun();
  endtask
  task floatCheck();
    lvl = 12'h4b0;
    tick(4);
    chk("fl latch", ovl, 1'b1);
    lvl = 12'h3e8;
    rel = 1'b1;
    tick(4);
    chk("fl held", ovl, 1'b1);
    rel = 1'b0;
    tick(4);
    chk("fl clear", ovl, 1'b0);
    chk("fl restart", ss, 1'b1);
  endtask
  task resetCheck();
    rst_b = 1'b0;
    tick(2);
    chk("rst lo", lo, 1'b0);
    chk("rst ss", ss, 1'b0);
    rst_b = 1'b1;
    tick(2);
    chk("rst start", ss, 1'b1);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #150000;
    badCount++;
    conclude();
  end
  initial begin
    {rst_b, en, rel, pwm, cs, slow} = 6'h00;
    sel = 5'h0a;
    lvl = 12'h3e8;
    tgt = 12'h3e8;
    sw = 10'h000;
    lim = 10'h0c8;
    badCount = 0;
    compares = 0;
    tick(4);
    chk("rst up", up, 1'b0);
    rst_b = 1'b1;
    idleCheck();
    startCheck();
    pwmCheck();
    fastCheck();
    ocCheck();
    ovCheck();
    floatCheck();
    resetCheck();
    conclude();
  end
endmodule
